// ===== hdl/fgdf_config.sv
// Fan tach mode, general-purpose pin and dynamic floor configuration slice
`timescale 1ns/100ps
`default_nettype none
module fgdf_config
   import fgdf_pkg::*;
#(
   parameter int PAIRS = NUM_PAIRS,
   parameter int PINS = NUM_PINS
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register port
   input wire fgdf_bus_req_type busReq,
   output logic [REG_DATA_W-1:0] rdData,
   // Fan drive mode and tach measurement controls
   input wire logic highFreqMode,
   output logic [PAIRS-1:0] continuousPair,
   output logic [PAIRS-1:0] pulseStretchEn,
   output logic [PAIRS-1:0] driveSyncEn,
   // General-purpose pins
   input wire logic [PINS-1:0] pinIn,
   input wire logic [PINS-1:0] pinAssertOut,
   output logic [PINS-1:0] pinOut,
   output logic [PINS-1:0] pinOe,
   output logic [PINS-1:0] pinAsserted,
   // Thermal alarm pins, sensed while driven from outside
   input wire logic [1:0] alarmIn_n,
   input wire logic [1:0] alarmSelfDrive,
   // Monitoring cycle and temperatures
   input wire logic monitorCycle,
   input wire fgdf_temp_pair_type presentTemp,
   input wire logic opPointWrEn,
   input wire fgdf_temp_pair_type opPointWrData,
   output fgdf_temp_pair_type opPoint,
   output logic [1:0] floorAdjustEn
);
   // Matches the pin synchroniser latency, so a released self-drive low is not seen as external
   localparam int SELF_MASK_DEPTH = 4;

   typedef struct packed {
      logic [REG_DATA_W-1:0] tachCont;
      logic [REG_DATA_W-1:0] pinCfgLow;
      logic [REG_DATA_W-1:0] pinCfgHigh;
      logic [REG_DATA_W-1:0] dynFloor;
      fgdf_temp_pair_type opPoint;
      logic [REG_DATA_W-1:0] rdData;
      logic [1:0] alarmSeen;
      logic [2*SELF_MASK_DEPTH-1:0] selfHist;
      logic [PINS-1:0] pinOut;
      logic [PINS-1:0] pinOe;
      logic [PINS-1:0] pinAsserted;
   } fgdf_state_type;

   fgdf_state_type state_reg, state_next;
   logic [PINS-1:0] pinSync;
   // Alarms enter inverted so the synchroniser's zero reset reads as idle
   logic [1:0] alarmAct;
   logic [PINS-1:0] polarity;
   logic [PINS-1:0] direction;

   fgdf_pin_sync #(.WIDTH(PINS + 2)) pinSyncInst (
      .clk(clk),
      .rst(rst),
      .pinIn({~alarmIn_n, pinIn}),
      .pinOut({alarmAct, pinSync})
   );

   // Even bits polarity, odd bits direction, for both registers
   function automatic logic [PINS-1:0] pick_bits(input logic [2*REG_DATA_W-1:0] cfg,
                                                 input int offs);
      logic [PINS-1:0] r;
      r = '0;
      for (int i = 0; i < PINS; i++) begin
         r[i] = cfg[2*i+offs];
      end
      return r;
   endfunction

   // Captures only downward; a hotter reading leaves the point alone
   function automatic logic [TEMP_W-1:0] capture(input logic go, input logic [TEMP_W-1:0] cur,
                                                 input logic [TEMP_W-1:0] held);
      return (go && cur < held) ? cur : held;
   endfunction

   always_comb begin
      polarity = pick_bits({state_reg.pinCfgHigh, state_reg.pinCfgLow}, 0);
      direction = pick_bits({state_reg.pinCfgHigh, state_reg.pinCfgLow}, 1);
   end

   always_comb begin
      logic [1:0] alarmHit;
      logic capS1;
      logic capS2;
      logic [1:0] selfMask;
      alarmHit = '0;
      capS1 = 1'b0;
      capS2 = 1'b0;
      selfMask = alarmSelfDrive;
      state_next = state_reg;
      // Register writes
      if (busReq.wrEn) begin
         case (busReq.addr)
            TACH_CONT_ADDR: begin
               state_next.tachCont = busReq.wrData & TACH_CONT_WMASK;
            end
            PIN_CFG_LOW_ADDR: begin
               state_next.pinCfgLow = busReq.wrData;
            end
            PIN_CFG_HIGH_ADDR: begin
               state_next.pinCfgHigh = busReq.wrData;
            end
            DYN_FLOOR_ADDR: begin
               state_next.dynFloor = busReq.wrData;
            end
            default: begin
               state_next.dynFloor = state_reg.dynFloor;
            end
         endcase
      end
      // Read data registered one cycle after the strobe
      if (busReq.rdEn) begin
         case (busReq.addr)
            TACH_CONT_ADDR: state_next.rdData = state_reg.tachCont;
            PIN_CFG_LOW_ADDR: state_next.rdData = state_reg.pinCfgLow;
            PIN_CFG_HIGH_ADDR: state_next.rdData = state_reg.pinCfgHigh;
            DYN_FLOOR_ADDR: state_next.rdData = state_reg.dynFloor;
            default: state_next.rdData = '0;
         endcase
      end
      // External assertion only: ignore lows the device drives itself,
      // until the synchroniser has caught up with the released pin
      for (int k = 0; k < SELF_MASK_DEPTH; k++) begin
         selfMask = selfMask | state_reg.selfHist[2*k +: 2];
      end
      state_next.selfHist = {state_reg.selfHist[2*SELF_MASK_DEPTH-3:0], alarmSelfDrive};
      for (int a = 0; a < 2; a++) begin
         if (alarmAct[a] && !selfMask[a]) begin
            state_next.alarmSeen[a] = 1'b1;
         end
      end
      // Evaluate once per monitoring cycle, then rearm; set wins over rearm
      if (monitorCycle) begin
         alarmHit = state_reg.alarmSeen;
         for (int a = 0; a < 2; a++) begin
            state_next.alarmSeen[a] = alarmAct[a] && !selfMask[a];
         end
         capS1 = (alarmHit[0] && state_reg.dynFloor[CAP_A1_S1_BIT])
            || (alarmHit[1] && state_reg.dynFloor[CAP_A2_S1_BIT]);
         capS2 = (alarmHit[0] && state_reg.dynFloor[CAP_A1_S2_BIT])
            || (alarmHit[1] && state_reg.dynFloor[CAP_A2_S2_BIT]);
      end
      if (opPointWrEn) begin
         state_next.opPoint = opPointWrData;
      end else begin
         state_next.opPoint.remote1 = capture(capS1, presentTemp.remote1,
                                              state_reg.opPoint.remote1);
         state_next.opPoint.remote2 = capture(capS2, presentTemp.remote2,
                                              state_reg.opPoint.remote2);
      end
      // Polarity folded into both drive and report
      state_next.pinOe = direction;
      state_next.pinOut = pinAssertOut ~^ polarity;
      state_next.pinAsserted = pinSync ~^ polarity;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= '0;
         state_reg.tachCont <= TACH_CONT_RESET;
         state_reg.pinCfgLow <= PIN_CFG_RESET;
         state_reg.pinCfgHigh <= PIN_CFG_RESET;
         state_reg.dynFloor <= DYN_FLOOR_RESET;
         state_reg.opPoint <= '1;
      end else begin
         state_reg <= state_next;
      end
   end

   // Continuous mode means nothing in high-frequency drive
   always_comb begin
      for (int p = 0; p < PAIRS; p++) begin
         continuousPair[p] = state_reg.tachCont[p] && !highFreqMode;
         pulseStretchEn[p] = !continuousPair[p] && !highFreqMode;
         driveSyncEn[p] = !continuousPair[p] && !highFreqMode;
      end
   end

   assign rdData = state_reg.rdData;
   assign opPoint = state_reg.opPoint;
   assign floorAdjustEn = {state_reg.dynFloor[FLOOR_EN_R2_BIT],
                           state_reg.dynFloor[FLOOR_EN_R1_BIT]};
   assign pinOut = state_reg.pinOut;
   assign pinOe = state_reg.pinOe;
   assign pinAsserted = state_reg.pinAsserted;
endmodule
`default_nettype wire

// ===== hdl/fgdf_pkg.sv
// Package: register map, field layout and carrier types of the fan/pin/floor configuration slice
package fgdf_pkg;
   localparam int REG_ADDR_W = 8;
   localparam int REG_DATA_W = 8;
   localparam logic [7:0] TACH_CONT_ADDR = 8'h08;
   localparam logic [7:0] PIN_CFG_LOW_ADDR = 8'h09;
   localparam logic [7:0] PIN_CFG_HIGH_ADDR = 8'h0A;
   localparam logic [7:0] DYN_FLOOR_ADDR = 8'h0B;
   localparam logic [7:0] TACH_CONT_RESET = 8'h0F;
   localparam logic [7:0] PIN_CFG_RESET = 8'h00;
   localparam logic [7:0] DYN_FLOOR_RESET = 8'h00;
   localparam logic [7:0] TACH_CONT_WMASK = 8'h0F;
   localparam int NUM_PAIRS = 4;
   localparam int NUM_PINS = 8;
   localparam int PINS_PER_REG = 4;
   localparam int TEMP_W = 8;
   // Dynamic floor control field positions
   localparam int FLOOR_EN_R1_BIT = 0;
   localparam int FLOOR_EN_R2_BIT = 1;
   localparam int CAP_A1_S1_BIT = 2;
   localparam int CAP_A1_S2_BIT = 3;
   localparam int CAP_A2_S1_BIT = 4;
   localparam int CAP_A2_S2_BIT = 5;

   // Register bus request
   typedef struct packed {
      logic wrEn;
      logic rdEn;
      logic [REG_ADDR_W-1:0] addr;
      logic [REG_DATA_W-1:0] wrData;
   } fgdf_bus_req_type;

   // Present remote temperatures and the operating points held beside them
   typedef struct packed {
      logic [TEMP_W-1:0] remote1;
      logic [TEMP_W-1:0] remote2;
   } fgdf_temp_pair_type;
endpackage

// ===== hdl/fgdf_pin_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/100ps
`default_nettype none
module fgdf_pin_sync
   import fgdf_pkg::*;
#(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Pins and filtered result
   input wire logic [WIDTH-1:0] pinIn,
   output logic [WIDTH-1:0] pinOut
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] level;
   } fgdf_sync_state_type;

   fgdf_sync_state_type state_reg, state_next;

   always_comb begin
      state_next = state_reg;
      state_next.s1 = pinIn;
      state_next.s2 = state_reg.s1;
      state_next.s3 = state_reg.s2;
      // Change counts only once stages two and three agree
      for (int i = 0; i < WIDTH; i++) begin
         if (state_reg.s2[i] == state_reg.s3[i]) begin
            state_next.level[i] = state_reg.s3[i];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign pinOut = state_reg.level;
endmodule
`default_nettype wire

// ===== verif/fgdf_config_checker.sv
// Port-level assertions for the configuration slice
`timescale 1ns/100ps
`default_nettype none
module fgdf_config_checker
   import fgdf_pkg::*;
#(
   parameter int PAIRS = NUM_PAIRS,
   parameter int PINS = NUM_PINS
) (
   // Slice inputs
   input wire logic clk,
   input wire logic rst,
   input wire fgdf_bus_req_type busReq,
   input wire logic highFreqMode,
   input wire logic monitorCycle,
   input wire logic opPointWrEn,
   input wire fgdf_temp_pair_type opPointWrData,
   // Slice outputs
   input wire logic [REG_DATA_W-1:0] rdData,
   input wire logic [PAIRS-1:0] continuousPair,
   input wire logic [PAIRS-1:0] pulseStretchEn,
   input wire logic [PAIRS-1:0] driveSyncEn,
   input wire logic [PINS-1:0] pinOe,
   input wire fgdf_temp_pair_type opPoint,
   input wire logic [1:0] floorAdjustEn
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   cont_map_a: assert property (
      busReq.wrEn && busReq.addr == TACH_CONT_ADDR |=> continuousPair ==
      ($past(busReq.wrData[PAIRS-1:0]) & {PAIRS{!highFreqMode}})) else $error("pair map wrong");
   stretch_off_a: assert property (
      pulseStretchEn == (~continuousPair & {PAIRS{!highFreqMode}}) && driveSyncEn == pulseStretchEn)
      else $error("stretch or sync wrong");
   tach_rsvd_a: assert property (
      busReq.rdEn && busReq.addr == TACH_CONT_ADDR |=> rdData[7:4] == 4'h0)
      else $error("reserved tach bits set");
   floor_en_a: assert property (
      busReq.wrEn && busReq.addr == DYN_FLOOR_ADDR |=> floorAdjustEn == $past(busReq.wrData[1:0]))
      else $error("floor enables wrong");
   pin_dir_a: assert property (
      busReq.wrEn && busReq.addr == PIN_CFG_LOW_ADDR ##1 !busReq.wrEn |=>
      pinOe[3:0] == {$past(busReq.wrData[7], 2), $past(busReq.wrData[5], 2),
      $past(busReq.wrData[3], 2), $past(busReq.wrData[1], 2)}) else $error("pin direction wrong");
   op_no_rise_a: assert property (
      !opPointWrEn |=> opPoint.remote1 <= $past(opPoint.remote1) &&
      opPoint.remote2 <= $past(opPoint.remote2)) else $error("operating point rose");
   op_load_a: assert property (
      opPointWrEn |=> opPoint == $past(opPointWrData)) else $error("operating point load lost");
   op_hold_a: assert property (
      !monitorCycle && !opPointWrEn |=> $stable(opPoint)) else $error("capture off cycle");
endmodule
bind fgdf_config fgdf_config_checker #(.PAIRS(PAIRS), .PINS(PINS)) i_chk(.*);
`default_nettype wire

// ===== verif/fgdf_config_tb.sv
// Self-checking bench for the configuration slice
`timescale 1ns/100ps
`default_nettype none
module fgdf_config_tb
   import fgdf_pkg::*;
();
   logic clk = 0, rst = 1, highFreqMode = 0, monitorCycle = 0, opPointWrEn = 0;
   fgdf_bus_req_type busReq = '0;
   logic [7:0] pinIn = 8'h00, pinAssertOut = 8'h00, rdData, pinOut, pinOe, pinAsserted;
   logic [3:0] continuousPair, pulseStretchEn, driveSyncEn;
   logic [1:0] alarmIn_n = 2'h3, alarmSelfDrive = 2'h0, floorAdjustEn;
   fgdf_temp_pair_type presentTemp = '0, opPointWrData = '0, opPoint;
   int error_cnt = 0, cmp_count = 0;
   fgdf_config i_dut(.*);
   initial forever #5 clk = ~clk;
   task automatic chk(input logic [23:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, d);
      @(posedge clk) busReq <= '{1'b1, 1'b0, a, d};
      @(posedge clk) busReq.wrEn <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, exp);
      @(posedge clk) busReq <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge clk) busReq.rdEn <= 1'b0;
      @(negedge clk) chk(rdData, exp);
   endtask
   // Gives the pin synchroniser time before each monitoring cycle ends
   task automatic pulse();
      repeat (6) @(posedge clk);
      monitorCycle <= 1'b1;
      @(posedge clk) monitorCycle <= 1'b0;
      @(negedge clk);
   endtask
   task automatic conclude();
      if (error_cnt == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      #200000;
      error_cnt++;
      conclude();
   end
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rd(TACH_CONT_ADDR, 8'h0F);
      rd(PIN_CFG_LOW_ADDR, 8'h00);
      rd(PIN_CFG_HIGH_ADDR, 8'h00);
      rd(DYN_FLOOR_ADDR, 8'h00);
      wr(8'h0C, 8'hFF);
      rd(8'h0C, 8'h00);
      wr(TACH_CONT_ADDR, 8'hF5);
      rd(TACH_CONT_ADDR, 8'h05);
      chk({continuousPair, pulseStretchEn, driveSyncEn}, 12'h5AA);
      @(posedge clk) highFreqMode <= 1'b1;
      @(negedge clk) chk({continuousPair, pulseStretchEn, driveSyncEn}, 12'h000);
      @(posedge clk) highFreqMode <= 1'b0;
      wr(PIN_CFG_LOW_ADDR, 8'hAA);
      wr(PIN_CFG_HIGH_ADDR, 8'h55);
      pinAssertOut <= 8'h05;
      pinIn <= 8'hA0;
      repeat (6) @(negedge clk);
      chk({pinOe, pinOut, pinAsserted[7:4]}, 20'h0F0AA);
      wr(DYN_FLOOR_ADDR, 8'hC3);
      rd(DYN_FLOOR_ADDR, 8'hC3);
      chk(floorAdjustEn, 2'h3);
      wr(DYN_FLOOR_ADDR, 8'h06);
      presentTemp <= 16'h4050;
      alarmIn_n <= 2'h2;
      pulse();
      chk({floorAdjustEn, opPoint}, 18'h240FF);
      @(posedge clk) presentTemp <= 16'h6030;
      pulse();
      chk(opPoint, 16'h40FF);
      wr(DYN_FLOOR_ADDR, 8'h20);
      alarmIn_n <= 2'h1;
      alarmSelfDrive <= 2'h2;
      pulse();
      chk(opPoint, 16'h40FF);
      @(posedge clk) alarmSelfDrive <= 2'h0;
      pulse();
      chk(opPoint, 16'h4030);
      wr(DYN_FLOOR_ADDR, 8'h18);
      alarmIn_n <= 2'h0;
      presentTemp <= 16'h2010;
      pulse();
      chk(opPoint, 16'h2010);
      @(posedge clk) opPointWrData <= 16'h7788;
      opPointWrEn <= 1'b1;
      @(posedge clk) opPointWrEn <= 1'b0;
      @(negedge clk) chk(opPoint, 16'h7788);
      conclude();
   end
endmodule
`default_nettype wire
